// ===== rtl/ptq_regs.vh
// Purpose: Register offsets, field positions and reset values
//          for the PHY test control and quick-poll status block
// Assumes: 5-bit management register addresses, 16-bit data
// Notes:   Definitions only
`ifndef PTQ_REGS_VH
`define PTQ_REGS_VH

// Register addresses
`define PTQ_EXT_CTRL_ADDR  5'h10
`define PTQ_QPOLL_ADDR     5'h11

// Extended control fields
`define PTQ_EC_CIPHER_TEST 5
`define PTQ_EC_NRZI        3
`define PTQ_EC_INV_CODE    2
`define PTQ_EC_CIPHER_OFF  0
`define PTQ_EC_RESET       16'h0008

// Quick-poll status fields
`define PTQ_QP_RATE        15
`define PTQ_QP_DUPLEX      14
`define PTQ_QP_AN_HI       13
`define PTQ_QP_AN_LO       11
`define PTQ_QP_SIG_LOST    10
`define PTQ_QP_LOCK_ERR    9
`define PTQ_QP_FALSE_CAR   8
`define PTQ_QP_INV_SYM     7
`define PTQ_QP_HALT_SYM    6
`define PTQ_QP_PREM_END    5
`define PTQ_QP_AN_DONE     4
`define PTQ_QP_NO_SIGNAL   3
`define PTQ_QP_JABBER      2
`define PTQ_QP_REM_FAULT   1
`define PTQ_QP_LINK        0
`define PTQ_QP_RESET       16'h0000

// Cipher key stream generator
`define PTQ_LFSR_SEED      11'h7FF

`endif

// ===== rtl/ptq_top.v
// Purpose: Transmit test controls, stream cipher and quick-poll
//          status register of a 10/100 Ethernet PHY
// Assumes: One clock; events arrive as one-cycle pulses from
//          logic on mclk; register access is one-cycle strobes
// Notes:   FIFO of 32 entries buffers MII transmit nibbles
`timescale 1ns/100ps
`default_nettype none
`include "ptq_regs.vh"

module ptq_fifo #(
   parameter WIDTH = 5,
   parameter DEPTH = 32,
   parameter AW    = 5
) (
   input  wire             mclk,
   input  wire             sys_rst,
   input  wire             ce,
   input  wire             in_valid,
   output wire             in_ready,
   input  wire [WIDTH-1:0] in_data,
   output wire             out_valid,
   input  wire             out_ready,
   output wire [WIDTH-1:0] out_data
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW-1:0]    wr_ptr;
   reg [AW-1:0]    rd_ptr;
   reg [AW:0]      count;
   wire            push;
   wire            pop;

   assign in_ready  = (count != DEPTH[AW:0]);
   assign out_valid = (count != {(AW+1){1'b0}});
   assign out_data  = mem[rd_ptr];
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;

   always @(posedge mclk) begin
      if (sys_rst) begin
         wr_ptr <= {AW{1'b0}};
         rd_ptr <= {AW{1'b0}};
         count  <= {(AW+1){1'b0}};
      end else if (ce) begin
         if (push) begin
            wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ?
                      {AW{1'b0}} : wr_ptr + 1'b1;
         end
         if (pop) begin
            rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ?
                      {AW{1'b0}} : rd_ptr + 1'b1;
         end
         if (push & ~pop) begin
            count <= count + 1'b1;
         end else if (pop & ~push) begin
            count <= count - 1'b1;
         end
      end
   end

   // Memory holds no reset so it maps onto plain RAM
   always @(posedge mclk) begin
      if (ce & push) begin
         mem[wr_ptr] <= in_data;
      end
   end
endmodule // ptq_fifo

module ptq_top #(
   parameter FIFO_DEPTH = 32,
   parameter FIFO_AW    = 5
) (
   input  wire        mclk,
   input  wire        sys_rst,
   input  wire        ce,
   input  wire        mgmt_wr,
   input  wire        mgmt_rd,
   input  wire [4:0]  mgmt_addr,
   input  wire [15:0] mgmt_wdata,
   output reg  [15:0] mgmt_rdata,
   output reg         mgmt_rvalid,
   input  wire        hw_mode_pin,
   input  wire        rate_select_pin,
   input  wire        duplex_select_pin,
   input  wire        sw_rate,
   input  wire        sw_duplex,
   input  wire        signal_present,
   input  wire        link_up,
   input  wire        ev_signal_lost,
   input  wire        ev_lock_error,
   input  wire        ev_false_carrier,
   input  wire        ev_invalid_symbol,
   input  wire        ev_halt_symbol,
   input  wire        ev_premature_end,
   input  wire        ev_jabber,
   input  wire        ev_remote_fault,
   input  wire        an_enable,
   input  wire        an_restart,
   input  wire [2:0]  an_state,
   input  wire        an_complete,
   input  wire        tx_en,
   input  wire [3:0]  txd,
   input  wire        tx_er,
   output wire        tx_ready,
   output reg         sym_valid,
   output reg  [4:0]  sym_data,
   input  wire        sym_ready,
   input  wire        rx_sym_valid,
   input  wire [4:0]  rx_sym,
   output reg         rx_out_valid,
   output reg  [4:0]  rx_out_data,
   output reg         nrzi_enable,
   output reg         cipher_test,
   output wire        cipher_active
);
   // Standard 4B/5B data code group
   function [4:0] ptq_std_code;
      input [3:0] n;
      begin
         case (n)
            4'h0:    ptq_std_code = 5'h1E;
            4'h1:    ptq_std_code = 5'h09;
            4'h2:    ptq_std_code = 5'h14;
            4'h3:    ptq_std_code = 5'h15;
            4'h4:    ptq_std_code = 5'h0A;
            4'h5:    ptq_std_code = 5'h0B;
            4'h6:    ptq_std_code = 5'h0E;
            4'h7:    ptq_std_code = 5'h0F;
            4'h8:    ptq_std_code = 5'h12;
            4'h9:    ptq_std_code = 5'h13;
            4'hA:    ptq_std_code = 5'h16;
            4'hB:    ptq_std_code = 5'h17;
            4'hC:    ptq_std_code = 5'h1A;
            4'hD:    ptq_std_code = 5'h1B;
            4'hE:    ptq_std_code = 5'h1C;
            default: ptq_std_code = 5'h1D;
         endcase
      end
   endfunction

   // Forced translation that lets invalid and control codes out
   function [4:0] ptq_test_code;
      input [3:0] n;
      begin
         case (n)
            4'h8:    ptq_test_code = 5'h00;
            4'h9:    ptq_test_code = 5'h0D;
            4'hA:    ptq_test_code = 5'h0C;
            4'hB:    ptq_test_code = 5'h11;
            4'hC:    ptq_test_code = 5'h10;
            4'hD:    ptq_test_code = 5'h19;
            4'hE:    ptq_test_code = 5'h18;
            4'hF:    ptq_test_code = 5'h1F;
            default: ptq_test_code = {1'b0, n};
         endcase
      end
   endfunction

   // Five key bits and the advanced state, shared by both paths
   function [15:0] ptq_step5;
      input [10:0] s;
      reg   [10:0] t;
      reg   [4:0]  k;
      integer      i;
      begin
         t = s;
         k = 5'h00;
         for (i = 0; i < 5; i = i + 1) begin
            k = {k[3:0], t[10] ^ t[8]};
            t = {t[9:0], t[10] ^ t[8]};
         end
         ptq_step5 = {k, t};
      end
   endfunction

   // Reset word kept as a sized constant so single bits can be picked
   localparam [15:0] EC_RST = `PTQ_EC_RESET;

   reg  [1:0]  hw_mode_sync;
   reg  [1:0]  rate_sync;
   reg  [1:0]  duplex_sync;
   reg  [1:0]  sig_sync;
   reg         inv_code_test;
   reg         cipher_off;
   reg  [2:0]  an_monitor;
   reg         lh_signal_lost;
   reg         lh_lock_error;
   reg         lh_false_carrier;
   reg         lh_invalid_symbol;
   reg         lh_halt_symbol;
   reg         lh_premature_end;
   reg         lh_jabber;
   reg         lh_remote_fault;
   reg         ll_link;
   reg  [10:0] tx_lfsr;
   reg  [10:0] rx_lfsr;
   wire        rate_status;
   wire        duplex_status;
   wire        qp_read;
   wire        ec_write;
   wire [15:0] ext_ctrl_value;
   wire [15:0] qpoll_value;
   wire        fifo_valid;
   wire        fifo_ready;
   wire [4:0]  fifo_data;
   wire [15:0] tx_step;
   wire [15:0] rx_step;
   wire [4:0]  tx_code;

   // Pins are asynchronous to mclk; only stage two is read
   always @(posedge mclk) begin
      if (sys_rst) begin
         hw_mode_sync <= 2'h0;
         rate_sync    <= 2'h0;
         duplex_sync  <= 2'h0;
         sig_sync     <= 2'h0;
      end else if (ce) begin
         hw_mode_sync <= {hw_mode_sync[0], hw_mode_pin};
         rate_sync    <= {rate_sync[0], rate_select_pin};
         duplex_sync  <= {duplex_sync[0], duplex_select_pin};
         sig_sync     <= {sig_sync[0], signal_present};
      end
   end

   // Configuration only, never link state
   assign rate_status   = hw_mode_sync[1] ? rate_sync[1] :
                          sw_rate;
   assign duplex_status = hw_mode_sync[1] ? duplex_sync[1] :
                          sw_duplex;

   assign qp_read  = mgmt_rd & (mgmt_addr == `PTQ_QPOLL_ADDR);
   assign ec_write = mgmt_wr & (mgmt_addr == `PTQ_EXT_CTRL_ADDR);

   // Reserved bits are dropped on write and read back zero
   always @(posedge mclk) begin
      if (sys_rst) begin
         inv_code_test <= EC_RST[`PTQ_EC_INV_CODE];
         cipher_off    <= EC_RST[`PTQ_EC_CIPHER_OFF];
         nrzi_enable   <= EC_RST[`PTQ_EC_NRZI];
         cipher_test   <= EC_RST[`PTQ_EC_CIPHER_TEST];
      end else if (ce & ec_write) begin
         inv_code_test <= mgmt_wdata[`PTQ_EC_INV_CODE];
         cipher_off    <= mgmt_wdata[`PTQ_EC_CIPHER_OFF];
         nrzi_enable   <= mgmt_wdata[`PTQ_EC_NRZI];
         cipher_test   <= mgmt_wdata[`PTQ_EC_CIPHER_TEST];
      end
   end

   assign ext_ctrl_value = {10'h000, cipher_test, 1'b0,
                            nrzi_enable, inv_code_test, 1'b0,
                            cipher_off};

   // Event in the read cycle wins, so it is seen on the next read
   always @(posedge mclk) begin
      if (sys_rst) begin
         lh_signal_lost    <= 1'b0;
         lh_lock_error     <= 1'b0;
         lh_false_carrier  <= 1'b0;
         lh_invalid_symbol <= 1'b0;
         lh_halt_symbol    <= 1'b0;
         lh_premature_end  <= 1'b0;
         lh_jabber         <= 1'b0;
         lh_remote_fault   <= 1'b0;
         ll_link           <= 1'b0;
      end else if (ce) begin
         lh_signal_lost    <= (lh_signal_lost & ~qp_read) |
                              ev_signal_lost;
         lh_lock_error     <= (lh_lock_error & ~qp_read) |
                              ev_lock_error;
         lh_false_carrier  <= (lh_false_carrier & ~qp_read) |
                              ev_false_carrier;
         lh_invalid_symbol <= (lh_invalid_symbol & ~qp_read) |
                              ev_invalid_symbol;
         lh_halt_symbol    <= (lh_halt_symbol & ~qp_read) |
                              ev_halt_symbol;
         lh_premature_end  <= (lh_premature_end & ~qp_read) |
                              ev_premature_end;
         lh_jabber         <= (lh_jabber & ~qp_read) |
                              ev_jabber;
         lh_remote_fault   <= (lh_remote_fault & ~qp_read) |
                              ev_remote_fault;
         ll_link           <= qp_read ? link_up :
                              (ll_link & link_up);
      end
   end

   // A read also reloads the monitor with the present state
   always @(posedge mclk) begin
      if (sys_rst) begin
         an_monitor <= 3'h0;
      end else if (ce) begin
         if (~an_enable | an_restart) begin
            an_monitor <= 3'h0;
         end else if (qp_read) begin
            an_monitor <= an_state;
         end else if (an_state > an_monitor) begin
            an_monitor <= an_state;
         end
      end
   end

   // Nothing here is writable; writes to it are ignored
   assign qpoll_value = {rate_status, duplex_status, an_monitor,
                         lh_signal_lost, lh_lock_error,
                         lh_false_carrier, lh_invalid_symbol,
                         lh_halt_symbol, lh_premature_end,
                         an_complete, ~sig_sync[1], lh_jabber,
                         lh_remote_fault, ll_link};

   // Answer carries the value from before any clear-on-read
   always @(posedge mclk) begin
      if (sys_rst) begin
         mgmt_rdata  <= `PTQ_QP_RESET;
         mgmt_rvalid <= 1'b0;
      end else if (ce) begin
         mgmt_rvalid <= mgmt_rd;
         if (mgmt_rd) begin
            case (mgmt_addr)
               `PTQ_EXT_CTRL_ADDR: mgmt_rdata <= ext_ctrl_value;
               `PTQ_QPOLL_ADDR:    mgmt_rdata <= qpoll_value;
               default:            mgmt_rdata <= 16'h0000;
            endcase
         end
      end
   end

   ptq_fifo #(
      .WIDTH (5),
      .DEPTH (FIFO_DEPTH),
      .AW    (FIFO_AW)
   ) u_tx_fifo (
      .mclk      (mclk),
      .sys_rst   (sys_rst),
      .ce        (ce),
      .in_valid  (tx_en),
      .in_ready  (tx_ready),
      .in_data   ({tx_er, txd}),
      .out_valid (fifo_valid),
      .out_ready (fifo_ready),
      .out_data  (fifo_data)
   );

   // Scrambling is a 100 Mb/s function only
   assign cipher_active = rate_status & ~cipher_off;
   assign tx_step       = ptq_step5(tx_lfsr);
   assign rx_step       = ptq_step5(rx_lfsr);
   assign fifo_ready    = ~sym_valid | sym_ready;

   // Test table needs both the control bit and the error strobe
   assign tx_code = (inv_code_test & fifo_data[4]) ?
                    ptq_test_code(fifo_data[3:0]) :
                    ptq_std_code(fifo_data[3:0]);

   // Output register stalls the FIFO while downstream is busy
   always @(posedge mclk) begin
      if (sys_rst) begin
         sym_valid <= 1'b0;
         sym_data  <= 5'h00;
         tx_lfsr   <= `PTQ_LFSR_SEED;
      end else if (ce) begin
         if (fifo_ready) begin
            sym_valid <= fifo_valid;
         end
         if (fifo_valid & fifo_ready) begin
            sym_data <= tx_code ^ (cipher_active ?
                        tx_step[15:11] : 5'h00);
            if (cipher_active) begin
               tx_lfsr <= tx_step[10:0];
            end
         end
      end
   end

   // Descrambler assumes key alignment is kept by the far end
   always @(posedge mclk) begin
      if (sys_rst) begin
         rx_out_valid <= 1'b0;
         rx_out_data  <= 5'h00;
         rx_lfsr      <= `PTQ_LFSR_SEED;
      end else if (ce) begin
         rx_out_valid <= rx_sym_valid;
         if (rx_sym_valid) begin
            rx_out_data <= rx_sym ^ (cipher_active ?
                           rx_step[15:11] : 5'h00);
            if (cipher_active) begin
               rx_lfsr <= rx_step[10:0];
            end
         end
      end
   end
endmodule // ptq_top
`default_nettype wire

// ===== dv/ptq_assertions.sv
// Purpose: Port-level checks for ptq_top
// Assumes: One clock; status bits read through one-cycle strobes
// Notes:   Bound to ptq_top after the module
`timescale 1ns/100ps
`default_nettype none
module ptq_chk (
   input wire logic        mclk,
   input wire logic        sys_rst,
   input wire logic        ce,
   input wire logic        mgmt_wr,
   input wire logic        mgmt_rd,
   input wire logic [4:0]  mgmt_addr,
   input wire logic [15:0] mgmt_wdata,
   input wire logic [15:0] mgmt_rdata,
   input wire logic        mgmt_rvalid,
   input wire logic        hw_mode_pin,
   input wire logic        sw_rate,
   input wire logic        sw_duplex,
   input wire logic        signal_present,
   input wire logic        link_up,
   input wire logic        ev_halt_symbol,
   input wire logic        ev_remote_fault,
   input wire logic        sym_valid,
   input wire logic [4:0]  sym_data,
   input wire logic        sym_ready,
   input wire logic        cipher_active
);
   logic       rd11;
   logic       calm;
   logic [3:0] cfg;
   logic [3:0] cfg_q;
   logic [1:0] quiet;
   assign rd11 = ce && mgmt_rd && mgmt_addr == 5'h11;
   assign calm = !ev_halt_symbol && !ev_remote_fault;
   assign cfg  = {hw_mode_pin, sw_rate, sw_duplex, signal_present};
   // Synchronisers lag the pins, so status checks wait for quiet inputs
   always @(posedge mclk) begin
      cfg_q <= cfg;
      if (sys_rst || cfg != cfg_q)
         quiet <= 2'h0;
      else if (quiet != 2'h3)
         quiet <= quiet + 2'h1;
   end
   default clocking cb @(posedge mclk); endclocking
   default disable iff (sys_rst);
   AST_RD_ANSWER:
      assert property (ce |=> mgmt_rvalid == $past(mgmt_rd))
      else $error("read answer wrong");
   AST_RSVD_ZERO:
      assert property (ce && mgmt_rd && mgmt_addr == 5'h10 |=>
         (mgmt_rdata & 16'hFFD2) == 16'h0000)
      else $error("reserved bits set");
   AST_SIG_INV:
      assert property (rd11 && quiet == 2'h3 |=>
         mgmt_rdata[3] == !$past(signal_present))
      else $error("signal detect wrong");
   AST_HALT_SET:
      assert property (ce && ev_halt_symbol ##1 rd11 |=> mgmt_rdata[6])
      else $error("halt bit not set");
   AST_FAULT_SET:
      assert property (ce && ev_remote_fault ##1 rd11 |=> mgmt_rdata[1])
      else $error("fault bit not set");
   AST_LH_CLEAR:
      assert property (rd11 && calm ##1 calm ##1 rd11 |=>
         (mgmt_rdata & 16'h0042) == 16'h0000)
      else $error("latched bit not cleared");
   AST_LINK_LOW:
      assert property (ce && !link_up ##1 rd11 |=> !mgmt_rdata[0])
      else $error("link bit not low");
   AST_RATE_SW:
      assert property (rd11 && quiet == 2'h3 && !hw_mode_pin |=>
         mgmt_rdata[15] == $past(sw_rate)
         && mgmt_rdata[14] == $past(sw_duplex))
      else $error("rate or duplex wrong");
   AST_SYM_HOLD:
      assert property (ce && sym_valid && !sym_ready |=>
         sym_valid && $stable(sym_data))
      else $error("code group dropped");
   AST_CIPHER_OFF:
      assert property (ce && mgmt_wr && mgmt_addr == 5'h10
         && mgmt_wdata[0] |=> !cipher_active)
      else $error("cipher not bypassed");
   AST_SLOW_PLAIN:
      assert property (quiet == 2'h3 && !hw_mode_pin && !sw_rate
         |-> !cipher_active)
      else $error("cipher at 10 Mb/s");
endmodule // ptq_chk
bind ptq_top ptq_chk u_chk (.*);
`default_nettype wire

// ===== dv/ptq_sink.sv
// Purpose: Code group sink on the line side of ptq_top
// Assumes: Ready moves shortly after the edge
// Notes:   Groups queue up in got for the bench
`timescale 1ns/100ps
`default_nettype none
module ptq_sink (
   input  wire logic       mclk,
   input  wire logic       stall,
   input  wire logic       sym_valid,
   input  wire logic [4:0] sym_data,
   output var  logic       sym_ready
);
   logic [4:0] got[$];
   initial sym_ready = 1'b0;
   always @(posedge mclk) begin
      if (sym_valid && sym_ready)
         got.push_back(sym_data);
      sym_ready <= #10 !stall;
   end
endmodule // ptq_sink
`default_nettype wire

// ===== dv/ptq_top_tb.sv
// Purpose: Self-checking bench for ptq_top
// Assumes: ce held high; strobes one cycle wide
// Notes:   Cipher traffic runs last so key streams start at seed
`timescale 1ns/100ps
`default_nettype none
module ptq_top_tb;
   logic        mclk, sys_rst, ce, mgmt_wr, mgmt_rd, mgmt_rvalid;
   logic [4:0]  mgmt_addr, sym_data, rx_sym, rx_out_data, k;
   logic [15:0] mgmt_wdata, mgmt_rdata;
   logic        hw_mode_pin, rate_select_pin, duplex_select_pin;
   logic        sw_rate, sw_duplex, signal_present, link_up, stall;
   logic        an_enable, an_restart, an_complete, tx_en, tx_er;
   logic        tx_ready, sym_valid, sym_ready, rx_sym_valid, full;
   logic        rx_out_valid, nrzi_enable, cipher_test, cipher_active;
   logic [2:0]  an_state;
   logic [3:0]  txd;
   logic [7:0]  ev;
   logic [10:0] txs, rxs;
   logic [4:0]  eq[$];
   int          err_count, num_checks, acc;
   logic [4:0]  std_t[16] = '{5'h1E, 5'h09, 5'h14, 5'h15, 5'h0A, 5'h0B,
      5'h0E, 5'h0F, 5'h12, 5'h13, 5'h16, 5'h17, 5'h1A, 5'h1B, 5'h1C, 5'h1D};
   logic [4:0]  inv_t[16] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05,
      5'h06, 5'h07, 5'h00, 5'h0D, 5'h0C, 5'h11, 5'h10, 5'h19, 5'h18, 5'h1F};
   ptq_top dut (.*, .ev_signal_lost(ev[7]), .ev_lock_error(ev[6]),
      .ev_false_carrier(ev[5]), .ev_invalid_symbol(ev[4]),
      .ev_halt_symbol(ev[3]), .ev_premature_end(ev[2]),
      .ev_jabber(ev[1]), .ev_remote_fault(ev[0]));
   ptq_sink mac (.mclk, .stall, .sym_valid, .sym_data, .sym_ready);
   initial begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end
   task chk(input string s, input logic [15:0] e, g);
      num_checks++;
      if (g !== e) begin
         err_count++;
         $display("FAIL %s exp %h got %h", s, e, g);
      end
   endtask
   task wreg(input logic [4:0] a, input logic [15:0] d);
      @(posedge mclk) #10;
      {mgmt_wr, mgmt_addr, mgmt_wdata} = {1'b1, a, d};
      @(posedge mclk) #10;
      mgmt_wr = 1'b0;
   endtask
   task rreg(input logic [4:0] a, input logic [15:0] e);
      @(posedge mclk) #10;
      {mgmt_rd, mgmt_addr} = {1'b1, a};
      @(posedge mclk) #10;
      mgmt_rd = 1'b0;
      chk("rvalid", 16'h0001, {15'h0, mgmt_rvalid});
      chk("rdata", e, mgmt_rdata);
   endtask
   task send(input logic [3:0] d, input logic er, input logic [4:0] e);
      @(posedge mclk) #10;
      {tx_en, txd, tx_er} = {1'b1, d, er};
      eq.push_back(e);
      @(posedge mclk) #10;
      tx_en = 1'b0;
   endtask
   task drain();
      for (int w = 0; w < 400 && mac.got.size() < eq.size(); w++)
         @(posedge mclk);
      chk("count", 16'(eq.size()), 16'(mac.got.size()));
      while (eq.size() > 0 && mac.got.size() > 0)
         chk("sym", {11'h0, eq.pop_front()}, {11'h0, mac.got.pop_front()});
      eq.delete();
      mac.got.delete();
   endtask
   task rxchk(input logic [4:0] d, e);
      @(posedge mclk) #10;
      {rx_sym_valid, rx_sym} = {1'b1, d};
      @(posedge mclk) #10;
      rx_sym_valid = 1'b0;
      chk("rx_valid", 16'h0001, {15'h0, rx_out_valid});
      chk("rx_data", {11'h0, e}, {11'h0, rx_out_data});
   endtask
   task ks(inout logic [10:0] s, output logic [4:0] q);
      repeat (5) begin
         s = {s[9:0], s[10] ^ s[8]};
         q = {q[3:0], s[0]};
      end
   endtask
   task conclude();
      $display("checks %0d mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   // Whole run needs about 330 cycles
   initial begin
      #(6000 * 100);
      err_count++;
      $display("FAIL watchdog exp done got hang");
      conclude();
   end
   initial begin
      {sys_rst, ce, mgmt_wr, mgmt_rd, hw_mode_pin, rate_select_pin} = 6'h30;
      {duplex_select_pin, sw_rate, sw_duplex, link_up, an_enable} = 5'h00;
      {an_restart, an_complete, tx_en, tx_er, rx_sym_valid} = 5'h00;
      {stall, signal_present, ev, an_state, txd} = 17'h08000;
      {mgmt_addr, mgmt_wdata, rx_sym} = 26'h0;
      repeat (3) @(posedge mclk);
      #10 sys_rst = 1'b0;
      repeat (4) @(posedge mclk);
      chk("nrzi", 16'h0001, {15'h0, nrzi_enable});
      rreg(5'h10, 16'h0008);
      rreg(5'h11, 16'h0000);
      rreg(5'h05, 16'h0000);
      wreg(5'h11, 16'hFFFF);
      rreg(5'h11, 16'h0000);
      wreg(5'h10, 16'hFFFF);
      rreg(5'h10, 16'h002D);
      chk("cipher_test", 16'h0001, {15'h0, cipher_test});
      wreg(5'h10, 16'h0008);
      $display("test registers done");
      for (int i = 0; i < 8; i++) begin
         @(posedge mclk) #10;
         ev = 8'h01 << i;
         @(posedge mclk) #10;
         ev = 8'h00;
         rreg(5'h11, 16'h0001 << (i < 2 ? i + 1 : i + 3));
         rreg(5'h11, 16'h0000);
      end
      for (int i = 0; i < 4; i++) begin
         {sw_rate, sw_duplex} = 2'(i);
         rreg(5'h11, {2'(i), 14'h0000});
      end
      {hw_mode_pin, rate_select_pin, duplex_select_pin, sw_duplex} = 4'hD;
      repeat (3) @(posedge mclk);
      rreg(5'h11, 16'h8000);
      {rate_select_pin, duplex_select_pin} = 2'b01;
      repeat (3) @(posedge mclk);
      rreg(5'h11, 16'h4000);
      // Back to software mode at 10 Mb/s; wait out the synchroniser
      {hw_mode_pin, sw_rate, sw_duplex} = 3'b000;
      repeat (3) @(posedge mclk) #10;
      link_up = 1'b1;
      rreg(5'h11, 16'h0000);
      rreg(5'h11, 16'h0001);
      @(posedge mclk) #10;
      link_up = 1'b0;
      @(posedge mclk) #10;
      link_up = 1'b1;
      rreg(5'h11, 16'h0000);
      rreg(5'h11, 16'h0001);
      {link_up, signal_present} = 2'b00;
      repeat (3) @(posedge mclk);
      rreg(5'h11, 16'h0008);
      signal_present = 1'b1;
      repeat (3) @(posedge mclk);
      rreg(5'h11, 16'h0000);
      {an_enable, an_state} = 4'hB;
      repeat (2) @(posedge mclk);
      an_state = 3'h1;
      rreg(5'h11, 16'h1800);
      rreg(5'h11, 16'h0800);
      an_restart = 1'b1;
      rreg(5'h11, 16'h0000);
      {an_enable, an_restart, an_complete} = 3'b001;
      rreg(5'h11, 16'h0010);
      an_complete = 1'b0;
      $display("test status done");
      chk("cipher_active", 16'h0000, {15'h0, cipher_active});
      rxchk(5'h15, 5'h15);
      wreg(5'h10, 16'h000C);
      for (int i = 0; i < 32; i++)
         send(4'(i), i < 16, i < 16 ? inv_t[i] : std_t[i % 16]);
      wreg(5'h10, 16'h0008);
      for (int i = 0; i < 16; i++)
         send(4'(i), 1'b1, std_t[i]);
      drain();
      // Stall the sink so the buffer must refuse
      @(posedge mclk) #10;
      stall = 1'b1;
      {acc, full, tx_er} = 0;
      for (int i = 0; i < 40; i++) begin
         {tx_en, txd} = {1'b1, 4'(i)};
         if (tx_ready)
            eq.push_back(std_t[i % 16]);
         full = full | !tx_ready;
         @(posedge mclk) #10;
      end
      tx_en = 1'b0;
      chk("refused", 16'h0001, {15'h0, full});
      acc = eq.size();
      chk("held", 16'h0001, {15'h0, acc >= 32 && acc <= 34});
      stall = 1'b0;
      drain();
      $display("test transmit done");
      sw_rate = 1'b1;
      repeat (2) @(posedge mclk);
      chk("cipher_active", 16'h0001, {15'h0, cipher_active});
      {txs, rxs} = 22'h3FFFFF;
      for (int i = 0; i < 4; i++) begin
         ks(txs, k);
         send(4'(i), 1'b0, std_t[i] ^ k);
      end
      drain();
      ks(rxs, k);
      rxchk(5'h00, k);
      wreg(5'h10, 16'h0009);
      chk("cipher_active", 16'h0000, {15'h0, cipher_active});
      send(4'h5, 1'b0, std_t[5]);
      drain();
      rxchk(5'h0A, 5'h0A);
      $display("test cipher done");
      conclude();
   end
endmodule // ptq_top_tb
`default_nettype wire
